// [rtl/ercrdw_top.sv]
// Embedded 256x16 RAM block with selectable clocking and collision handling
module ercrdw_top
  import ercrdw_pkg::*;
#(
  parameter ercrdw_mem_t MEM_MODE = ERCRDW_MEM_TRUE_DP,
  parameter ercrdw_clk_t CLK_SCHEME = ERCRDW_CLK_INDEP,
  parameter logic OUT_BYPASS = 1'b0,
  parameter logic NEG_EDGE_READ = 1'b0,
  parameter logic MIXED_OLD_DATA = 1'b1,
  parameter logic SHARED_CLOCK = 1'b1
)
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic A_IN_TICK_IN,
  input wire logic A_IN_FALL_IN,
  input wire logic A_IN_CE_IN,
  input wire logic A_IN_CLR_IN,
  input wire logic A_OUT_TICK_IN,
  input wire logic A_OUT_CE_IN,
  input wire logic A_OUT_CLR_IN,
  input wire logic [ADDR_W-1:0] A_ADDR_IN,
  input wire logic [DATA_W-1:0] A_DATA_IN,
  input wire logic [NUM_BYTES-1:0] A_BE_IN,
  input wire logic A_WREN_IN,
  input wire logic A_RDEN_IN,
  output logic [DATA_W-1:0] A_Q_OUT,
  input wire logic B_IN_TICK_IN,
  input wire logic B_IN_FALL_IN,
  input wire logic B_IN_CE_IN,
  input wire logic B_IN_CLR_IN,
  input wire logic B_OUT_TICK_IN,
  input wire logic B_OUT_CE_IN,
  input wire logic B_OUT_CLR_IN,
  input wire logic [ADDR_W-1:0] B_ADDR_IN,
  input wire logic [DATA_W-1:0] B_DATA_IN,
  input wire logic [NUM_BYTES-1:0] B_BE_IN,
  input wire logic B_WREN_IN,
  input wire logic B_RDEN_IN,
  output logic [DATA_W-1:0] B_Q_OUT,
  output logic CFG_ERR_OUT
);
  // Configuration is static; nothing below may change it at run time
  localparam logic CFG_OK = ercrdw_legal(MEM_MODE, CLK_SCHEME);
  localparam logic DUAL_PORT = (MEM_MODE != ERCRDW_MEM_SINGLE);
  localparam logic SPLIT_OUT = (CLK_SCHEME == ERCRDW_CLK_INOUT);
  localparam logic SAME_PORT_RDW = (MEM_MODE != ERCRDW_MEM_SIMPLE_DP);
  localparam logic USE_FALL = NEG_EDGE_READ && OUT_BYPASS && DUAL_PORT;

  // Port-level views after scheme mapping
  logic a_wcap, a_rcap, b_wcap, b_rcap;
  logic a_otick, a_oce, a_oclr, b_otick, b_oce, b_oclr;
  logic a_wren_ok, a_rden_ok, b_wren_ok, b_rden_ok;
  logic [ADDR_W-1:0] a_addr_map, b_addr_map;

  // Registered port state from the input groups
  logic [ADDR_W-1:0] a_waddr, a_raddr, b_waddr, b_raddr;
  logic [DATA_W-1:0] a_wdata, b_wdata;
  logic [NUM_BYTES-1:0] a_be, b_be;
  logic a_rden, b_rden;
  logic a_wgo, a_rgo, b_wgo, b_rgo;

  // Array and read path
  logic [DATA_W-1:0] mem_ff [DEPTH];
  logic [DATA_W-1:0] a_rd_ff, nxt_a_rd;
  logic [DATA_W-1:0] b_rd_ff, nxt_b_rd;
  logic [DATA_W-1:0] a_oreg_ff, nxt_a_oreg;
  logic [DATA_W-1:0] b_oreg_ff, nxt_b_oreg;

  // Two single-port RAMs share the block by each owning one address half
  function automatic logic [ADDR_W-1:0] map_addr(input logic [ADDR_W-1:0] addr,
                                                 input logic half);
    logic [ADDR_W-1:0] res;
    res = addr;
    if (MEM_MODE == ERCRDW_MEM_SINGLE)
    begin
      res[HALF_BIT] = half;
    end
    map_addr = res;
  endfunction : map_addr

  // Merge of new write data into the stored word by byte enable
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_word,
                                                    input logic [DATA_W-1:0] new_word,
                                                    input logic [NUM_BYTES-1:0] be);
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < NUM_BYTES; i++)
    begin
      if (be[i])
      begin
        res[i*BYTE_W +: BYTE_W] = new_word[i*BYTE_W +: BYTE_W];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  // Result of one read, given both ports' write activity in the same cycle
  function automatic logic [DATA_W-1:0] read_result(
    input logic [DATA_W-1:0] stored,
    input logic [ADDR_W-1:0] raddr,
    input logic self_wgo,
    input logic [ADDR_W-1:0] self_waddr,
    input logic [DATA_W-1:0] self_wdata,
    input logic [NUM_BYTES-1:0] self_be,
    input logic other_wgo,
    input logic [ADDR_W-1:0] other_waddr
  );
    logic [DATA_W-1:0] res;
    res = stored;
    if (SAME_PORT_RDW && self_wgo && (self_waddr == raddr))
    begin
      // Masked bytes have no defined value during a same-port collision
      res = merge_bytes(UNDEFINED_VALUE, self_wdata, self_be);
    end
    else if (other_wgo && (other_waddr == raddr))
    begin
      if (SHARED_CLOCK && MIXED_OLD_DATA)
      begin
        res = stored;
      end
      else
      begin
        res = UNDEFINED_VALUE;
      end
    end
    read_result = res;
  endfunction : read_result

  // Clock group mapping per scheme
  always_comb
  begin
    a_wcap = A_IN_TICK_IN;
    b_wcap = B_IN_TICK_IN;
    // Falling-edge read capture trades a full cycle for same-cycle data
    a_rcap = USE_FALL ? A_IN_FALL_IN : A_IN_TICK_IN;
    b_rcap = USE_FALL ? B_IN_FALL_IN : B_IN_TICK_IN;
    if (SPLIT_OUT)
    begin
      a_otick = A_OUT_TICK_IN;
      a_oce = A_OUT_CE_IN;
      a_oclr = A_OUT_CLR_IN;
      b_otick = B_OUT_TICK_IN;
      b_oce = B_OUT_CE_IN;
      b_oclr = B_OUT_CLR_IN;
    end
    else
    begin
      // Read-side output follows the port's single clock, enable and clear
      a_otick = A_IN_TICK_IN;
      a_oce = A_IN_CE_IN;
      a_oclr = A_IN_CLR_IN;
      b_otick = B_IN_TICK_IN;
      b_oce = B_IN_CE_IN;
      b_oclr = B_IN_CLR_IN;
    end
  end

  // Port roles: simple dual-port writes on A and reads on B only
  always_comb
  begin
    a_wren_ok = A_WREN_IN && CFG_OK;
    a_rden_ok = A_RDEN_IN && CFG_OK && (MEM_MODE != ERCRDW_MEM_SIMPLE_DP);
    b_wren_ok = B_WREN_IN && CFG_OK && (MEM_MODE != ERCRDW_MEM_SIMPLE_DP);
    b_rden_ok = B_RDEN_IN && CFG_OK;
    a_addr_map = map_addr(A_ADDR_IN, HALF_LOW);
    b_addr_map = map_addr(B_ADDR_IN, HALF_HIGH);
  end

  ercrdw_inreg u_port_a (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .wcap_in(a_wcap),
    .rcap_in(a_rcap),
    .ce_in(A_IN_CE_IN),
    .clr_in(A_IN_CLR_IN),
    .addr_in(a_addr_map),
    .data_in(A_DATA_IN),
    .be_in(A_BE_IN),
    .wren_in(a_wren_ok),
    .rden_in(a_rden_ok),
    .waddr_out(a_waddr),
    .raddr_out(a_raddr),
    .data_out(a_wdata),
    .be_out(a_be),
    .rden_out(a_rden),
    .wgo_out(a_wgo),
    .rgo_out(a_rgo)
  );

  ercrdw_inreg u_port_b (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .wcap_in(b_wcap),
    .rcap_in(b_rcap),
    .ce_in(B_IN_CE_IN),
    .clr_in(B_IN_CLR_IN),
    .addr_in(b_addr_map),
    .data_in(B_DATA_IN),
    .be_in(B_BE_IN),
    .wren_in(b_wren_ok),
    .rden_in(b_rden_ok),
    .waddr_out(b_waddr),
    .raddr_out(b_raddr),
    .data_out(b_wdata),
    .be_out(b_be),
    .rden_out(b_rden),
    .wgo_out(b_wgo),
    .rgo_out(b_rgo)
  );

  // Array commit in the cycle after capture; dual writes to one word are
  // left to user logic, port B simply lands last here
  always_ff @(posedge MCLK_IN)
  begin
    if (a_wgo)
    begin
      mem_ff[a_waddr] <= merge_bytes(mem_ff[a_waddr], a_wdata, a_be);
    end
    if (b_wgo)
    begin
      mem_ff[b_waddr] <= merge_bytes(mem_ff[b_waddr], b_wdata, b_be);
    end
  end

  // Read data and optional output registers
  always_comb
  begin
    nxt_a_rd = a_rd_ff;
    nxt_b_rd = b_rd_ff;
    nxt_a_oreg = a_oreg_ff;
    nxt_b_oreg = b_oreg_ff;
    if (a_rgo && a_rden)
    begin
      nxt_a_rd = read_result(mem_ff[a_raddr], a_raddr, a_wgo, a_waddr, a_wdata, a_be,
                             b_wgo, b_waddr);
    end
    if (b_rgo && b_rden)
    begin
      nxt_b_rd = read_result(mem_ff[b_raddr], b_raddr, b_wgo, b_waddr, b_wdata, b_be,
                             a_wgo, a_waddr);
    end
    if (a_otick && a_oce)
    begin
      nxt_a_oreg = a_oclr ? DATA_RESET : a_rd_ff;
    end
    if (b_otick && b_oce)
    begin
      nxt_b_oreg = b_oclr ? DATA_RESET : b_rd_ff;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      a_rd_ff <= DATA_RESET;
      b_rd_ff <= DATA_RESET;
      a_oreg_ff <= DATA_RESET;
      b_oreg_ff <= DATA_RESET;
    end
    else
    begin
      a_rd_ff <= nxt_a_rd;
      b_rd_ff <= nxt_b_rd;
      a_oreg_ff <= nxt_a_oreg;
      b_oreg_ff <= nxt_b_oreg;
    end
  end

  // Bypass skips the extra output stage
  assign A_Q_OUT = OUT_BYPASS ? a_rd_ff : a_oreg_ff;
  assign B_Q_OUT = OUT_BYPASS ? b_rd_ff : b_oreg_ff;
  assign CFG_ERR_OUT = !CFG_OK;
endmodule : ercrdw_top

// [rtl/ercrdw_pkg.sv]
// Shared constants, types and helpers for the embedded RAM clocking block
// Function
// - Each clocking scheme is legal only with its matching memory configuration; input/output clocking takes either dual-port mode.
// - Independent clocking gives each port its own clock for all its registers.
// - Independent clocking gives each port its own clock enable and clear.
// - Input/output clocking captures inputs on one clock, read data on another.
// - Input/output clocking has separate enables and clears for input and output groups.
// - Read/write clocking: write clock takes write inputs, read clock the read side.
// - Read/write clocking has one enable per clock and separate side clears.
// - Single-port clocking lets one block host two separate single-port RAMs.
// - All inputs are registered and the write pulse is generated internally.
// - Output registers are optional; bypassed, read data leaves the array directly.
// - Falling-edge read capture plus bypass returns data in the address cycle, in the dual-port modes only.
// - Clears act aligned to the port clock, never immediately.
// - Same-port read of the address being written returns the new data.
// - Same-port byte-masked read-during-write gives undefined masked bytes.
// - Mixed-port collision on a shared clock gives old data or undefined.
// - The array commits write data at the write clock's falling edge; the code commits on the MCLK rising edge one cycle after capture.
// - With the read strobe low the read data hold their last value.
package ercrdw_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 2;
  localparam int DEPTH = 256;
  localparam int HALF_BIT = ADDR_W - 1;
  // Pattern shown wherever the hardware result is undefined
  localparam logic [DATA_W-1:0] UNDEFINED_VALUE = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [NUM_BYTES-1:0] BE_RESET = 2'h0;
  // A cleared read-strobe register reads as enabled
  localparam logic RDEN_CLEAR = 1'b1;
  localparam logic HALF_LOW = 1'b0;
  localparam logic HALF_HIGH = 1'b1;

  typedef enum logic [1:0] {
    ERCRDW_CLK_INDEP,
    ERCRDW_CLK_INOUT,
    ERCRDW_CLK_RDWR,
    ERCRDW_CLK_SINGLE
  } ercrdw_clk_t;

  typedef enum logic [1:0] {
    ERCRDW_MEM_TRUE_DP,
    ERCRDW_MEM_SIMPLE_DP,
    ERCRDW_MEM_SINGLE
  } ercrdw_mem_t;

  function automatic logic ercrdw_legal(input ercrdw_mem_t mem, input ercrdw_clk_t clk);
    unique case (clk)
      ERCRDW_CLK_INDEP: ercrdw_legal = (mem == ERCRDW_MEM_TRUE_DP);
      ERCRDW_CLK_INOUT: ercrdw_legal = (mem != ERCRDW_MEM_SINGLE);
      ERCRDW_CLK_RDWR: ercrdw_legal = (mem == ERCRDW_MEM_SIMPLE_DP);
      ERCRDW_CLK_SINGLE: ercrdw_legal = (mem == ERCRDW_MEM_SINGLE);
    endcase
  endfunction : ercrdw_legal
endpackage : ercrdw_pkg

// [rtl/ercrdw_inreg.sv]
// Input register group of one RAM port with internally timed write pulse
module ercrdw_inreg
  import ercrdw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wcap_in,
  input wire logic rcap_in,
  input wire logic ce_in,
  input wire logic clr_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [NUM_BYTES-1:0] be_in,
  input wire logic wren_in,
  input wire logic rden_in,
  output logic [ADDR_W-1:0] waddr_out,
  output logic [ADDR_W-1:0] raddr_out,
  output logic [DATA_W-1:0] data_out,
  output logic [NUM_BYTES-1:0] be_out,
  output logic rden_out,
  output logic wgo_out,
  output logic rgo_out
);
  logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
  logic [ADDR_W-1:0] raddr_ff, nxt_raddr;
  logic [DATA_W-1:0] data_ff, nxt_data;
  logic [NUM_BYTES-1:0] be_ff, nxt_be;
  logic rden_ff, nxt_rden;
  logic wgo_ff, nxt_wgo;
  logic rgo_ff, nxt_rgo;

  always_comb
  begin
    nxt_waddr = waddr_ff;
    nxt_raddr = raddr_ff;
    nxt_data = data_ff;
    nxt_be = be_ff;
    nxt_rden = rden_ff;
    // Write pulse fires one cycle after capture, standing for the falling edge
    nxt_wgo = 1'b0;
    nxt_rgo = 1'b0;
    if (wcap_in && ce_in)
    begin
      if (clr_in)
      begin
        nxt_waddr = ADDR_RESET;
        nxt_data = DATA_RESET;
        nxt_be = BE_RESET;
      end
      else
      begin
        nxt_waddr = addr_in;
        nxt_data = data_in;
        nxt_be = be_in;
        nxt_wgo = wren_in;
      end
    end
    if (rcap_in && ce_in)
    begin
      if (clr_in)
      begin
        nxt_raddr = ADDR_RESET;
        nxt_rden = RDEN_CLEAR;
      end
      else
      begin
        nxt_raddr = addr_in;
        nxt_rden = rden_in;
        nxt_rgo = rden_in;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      waddr_ff <= ADDR_RESET;
      raddr_ff <= ADDR_RESET;
      data_ff <= DATA_RESET;
      be_ff <= BE_RESET;
      rden_ff <= RDEN_CLEAR;
      wgo_ff <= 1'b0;
      rgo_ff <= 1'b0;
    end
    else
    begin
      waddr_ff <= nxt_waddr;
      raddr_ff <= nxt_raddr;
      data_ff <= nxt_data;
      be_ff <= nxt_be;
      rden_ff <= nxt_rden;
      wgo_ff <= nxt_wgo;
      rgo_ff <= nxt_rgo;
    end
  end

  assign waddr_out = waddr_ff;
  assign raddr_out = raddr_ff;
  assign data_out = data_ff;
  assign be_out = be_ff;
  assign rden_out = rden_ff;
  assign wgo_out = wgo_ff;
  assign rgo_out = rgo_ff;
endmodule : ercrdw_inreg

// [verif/ercrdw_props.sv]
// Port-level assertions for the embedded RAM block
module ercrdw_props
  import ercrdw_pkg::*;
#(
  parameter ercrdw_mem_t MEM_MODE = ERCRDW_MEM_TRUE_DP,
  parameter ercrdw_clk_t CLK_SCHEME = ERCRDW_CLK_INDEP
)
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic A_IN_TICK_IN,
  input wire logic A_IN_CE_IN,
  input wire logic A_IN_CLR_IN,
  input wire logic [DATA_W-1:0] A_DATA_IN,
  input wire logic [NUM_BYTES-1:0] A_BE_IN,
  input wire logic A_WREN_IN,
  input wire logic A_RDEN_IN,
  input wire logic [DATA_W-1:0] A_Q_OUT,
  input wire logic B_IN_TICK_IN,
  input wire logic B_IN_CE_IN,
  input wire logic B_IN_CLR_IN,
  input wire logic [DATA_W-1:0] B_DATA_IN,
  input wire logic [NUM_BYTES-1:0] B_BE_IN,
  input wire logic B_WREN_IN,
  input wire logic B_RDEN_IN,
  input wire logic [DATA_W-1:0] B_Q_OUT,
  input wire logic CFG_ERR_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic LEGAL = (CLK_SCHEME == ERCRDW_CLK_INDEP && MEM_MODE == ERCRDW_MEM_TRUE_DP)
    || (CLK_SCHEME == ERCRDW_CLK_INOUT && MEM_MODE != ERCRDW_MEM_SINGLE)
    || (CLK_SCHEME == ERCRDW_CLK_RDWR && MEM_MODE == ERCRDW_MEM_SIMPLE_DP)
    || (CLK_SCHEME == ERCRDW_CLK_SINGLE && MEM_MODE == ERCRDW_MEM_SINGLE);
  logic cap_a;
  logic cap_b;
  assign cap_a = A_IN_TICK_IN && A_IN_CE_IN;
  assign cap_b = B_IN_TICK_IN && B_IN_CE_IN;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  chk_cfg_flag: assert property (CFG_ERR_OUT == !LEGAL)
    else $error("config error flag wrong");
  chk_hold_a: assert property (!cap_a ##1 !cap_a |=> $stable(A_Q_OUT))
    else $error("port A data moved without capture");
  chk_hold_b_indep: assert property ((!cap_b)[*2] |=> $stable(B_Q_OUT))
    else $error("port B data moved without its own capture");
  chk_rden_low_hold: assert property (!cap_a ##1 (cap_a && !A_RDEN_IN && !A_IN_CLR_IN)
    |=> $stable(A_Q_OUT))
    else $error("port A data moved on capture without read");
  chk_clr_aligned: assert property (!cap_a ##1 (A_IN_CLR_IN && !cap_a) |=> $stable(A_Q_OUT))
    else $error("port A clear acted without a tick");
  chk_rdw_new_a: assert property (cap_a && A_WREN_IN && A_RDEN_IN && A_BE_IN == 2'h3
    && !A_IN_CLR_IN |=> ##1 A_Q_OUT == $past(A_DATA_IN, 2))
    else $error("port A read during write not new data");
  chk_rdw_new_b: assert property (cap_b && B_WREN_IN && B_RDEN_IN && B_BE_IN == 2'h3
    && !B_IN_CLR_IN |-> ##2 B_Q_OUT == $past(B_DATA_IN, 2))
    else $error("port B read during write not new data");
  chk_byte_mask: assert property (cap_a && A_WREN_IN && A_RDEN_IN && A_BE_IN == 2'h1
    && !A_IN_CLR_IN |-> ##2 A_Q_OUT == {UNDEFINED_VALUE[DATA_W-1:BYTE_W],
    $past(A_DATA_IN[BYTE_W-1:0], 2)})
    else $error("masked read during write wrong");
endmodule : ercrdw_props
bind ercrdw_top ercrdw_props #(.MEM_MODE(MEM_MODE), .CLK_SCHEME(CLK_SCHEME)) props_u (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .A_IN_TICK_IN(A_IN_TICK_IN), .A_IN_CE_IN(A_IN_CE_IN),
  .A_IN_CLR_IN(A_IN_CLR_IN), .A_DATA_IN(A_DATA_IN), .A_BE_IN(A_BE_IN), .A_WREN_IN(A_WREN_IN),
  .A_RDEN_IN(A_RDEN_IN), .A_Q_OUT(A_Q_OUT), .B_IN_TICK_IN(B_IN_TICK_IN),
  .B_IN_CE_IN(B_IN_CE_IN), .B_IN_CLR_IN(B_IN_CLR_IN), .B_DATA_IN(B_DATA_IN),
  .B_BE_IN(B_BE_IN), .B_WREN_IN(B_WREN_IN), .B_RDEN_IN(B_RDEN_IN), .B_Q_OUT(B_Q_OUT),
  .CFG_ERR_OUT(CFG_ERR_OUT)
);

// [verif/ercrdw_fabric.sv]
// Fabric-side user logic that drives port B of the RAM block
module ercrdw_fabric
  import ercrdw_pkg::*;
(
  input wire logic clk_in,
  output logic tick_out,
  output logic ce_out,
  output logic clr_out,
  output logic wren_out,
  output logic rden_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] data_out,
  output logic [NUM_BYTES-1:0] be_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {tick_out, ce_out, clr_out, wren_out, rden_out} = 5'h00;
    addr_out = 8'h00;
    data_out = 16'h0000;
    be_out = 2'h0;
  end
  // Runs on the same MCLK as port A, so collisions stay defined
  // Callers never aim a write at a word port A writes in that cycle
  task automatic b_op(input logic wr, rd, clr, ce, input logic [ADDR_W-1:0] ad,
    input logic [DATA_W-1:0] d, input logic [NUM_BYTES-1:0] be);
    @(posedge clk_in);
    tick_out <= 1'b1;
    ce_out <= ce;
    clr_out <= clr;
    wren_out <= wr;
    rden_out <= rd;
    addr_out <= ad;
    data_out <= d;
    be_out <= be;
    @(posedge clk_in);
    tick_out <= 1'b0;
    clr_out <= 1'b0;
    wren_out <= 1'b0;
    rden_out <= 1'b0;
    // Released lines flip so nothing leans on a stale value
    addr_out <= ~ad;
    data_out <= ~d;
  endtask : b_op
endmodule : ercrdw_fabric

// [verif/tb_ercrdw_top.sv]
// Self-checking bench for the embedded RAM block, port B from the fabric model
module tb_ercrdw_top
  import ercrdw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic p; logic [7:0] ad; logic [15:0] d; logic [1:0] be; logic [15:0] exp;}
    ercrdw_row_t;
  // Write from port p, read back from the other port
  ercrdw_row_t rows[5] = '{'{1'b0, 8'h10, 16'h1234, 2'h3, 16'h1234},
    '{1'b0, 8'h10, 16'habcd, 2'h1, 16'h12cd}, '{1'b1, 8'h10, 16'h5678, 2'h2, 16'h56cd},
    '{1'b1, 8'hff, 16'hbeef, 2'h3, 16'hbeef}, '{1'b0, 8'h00, 16'h0f0f, 2'h3, 16'h0f0f}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic a_tick = 1'b0, a_ce = 1'b0, a_clr = 1'b0, a_wren = 1'b0, a_rden = 1'b0;
  logic [ADDR_W-1:0] a_addr = 8'h00;
  logic [DATA_W-1:0] a_data = 16'h0000;
  logic [NUM_BYTES-1:0] a_be = 2'h0;
  logic b_tick, b_ce, b_clr, b_wren, b_rden, cfg_err;
  logic [ADDR_W-1:0] b_addr;
  logic [DATA_W-1:0] b_data, a_q, b_q, q, q0;
  logic [NUM_BYTES-1:0] b_be;
  int err_total = 0;
  int n_checks = 0;
  // Bypassed outputs give a fixed one-cycle read latency
  ercrdw_top #(.OUT_BYPASS(1'b1)) dut_u (.MCLK_IN(clk), .RST_IN(rst),
    .A_IN_TICK_IN(a_tick), .A_IN_FALL_IN(1'b0), .A_IN_CE_IN(a_ce), .A_IN_CLR_IN(a_clr),
    .A_OUT_TICK_IN(a_tick), .A_OUT_CE_IN(a_ce), .A_OUT_CLR_IN(a_clr), .A_ADDR_IN(a_addr),
    .A_DATA_IN(a_data), .A_BE_IN(a_be), .A_WREN_IN(a_wren), .A_RDEN_IN(a_rden), .A_Q_OUT(a_q),
    .B_IN_TICK_IN(b_tick), .B_IN_FALL_IN(1'b0), .B_IN_CE_IN(b_ce), .B_IN_CLR_IN(b_clr),
    .B_OUT_TICK_IN(b_tick), .B_OUT_CE_IN(b_ce), .B_OUT_CLR_IN(b_clr), .B_ADDR_IN(b_addr),
    .B_DATA_IN(b_data), .B_BE_IN(b_be), .B_WREN_IN(b_wren), .B_RDEN_IN(b_rden), .B_Q_OUT(b_q),
    .CFG_ERR_OUT(cfg_err));
  ercrdw_fabric fab_u (.clk_in(clk), .tick_out(b_tick), .ce_out(b_ce), .clr_out(b_clr),
    .wren_out(b_wren), .rden_out(b_rden), .addr_out(b_addr), .data_out(b_data), .be_out(b_be));
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [DATA_W-1:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic port_op(input logic p, wr, rd, clr, ce, input logic [ADDR_W-1:0] ad,
    input logic [DATA_W-1:0] d, input logic [NUM_BYTES-1:0] be);
    if (p)
      fab_u.b_op(wr, rd, clr, ce, ad, d, be);
    else
    begin
      @(posedge clk);
      {a_tick, a_wren, a_rden, a_clr, a_ce} <= {1'b1, wr, rd, clr, ce};
      {a_addr, a_data, a_be} <= {ad, d, be};
      @(posedge clk);
      {a_tick, a_wren, a_rden, a_clr} <= 4'h0;
      {a_addr, a_data} <= {~ad, ~d};
    end
  endtask : port_op
  task automatic op_q(input logic p, wr, rd, clr, ce, input logic [ADDR_W-1:0] ad,
    input logic [DATA_W-1:0] d, input logic [NUM_BYTES-1:0] be, output logic [DATA_W-1:0] qv);
    port_op(p, wr, rd, clr, ce, ad, d, be);
    @(posedge clk);
    #1;
    qv = p ? b_q : a_q;
  endtask : op_q
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(a_q, DATA_RESET);
    check(b_q, DATA_RESET);
    check({15'h0000, cfg_err}, 16'h0000);
    foreach (rows[i])
    begin
      port_op(rows[i].p, 1'b1, 1'b0, 1'b0, 1'b1, rows[i].ad, rows[i].d, rows[i].be);
      op_q(!rows[i].p, 1'b0, 1'b1, 1'b0, 1'b1, rows[i].ad, 16'h0000, 2'h0, q);
      check(q, rows[i].exp);
    end
    op_q(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h20, 16'h1111, 2'h3, q);
    check(q, 16'h1111);
    op_q(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h21, 16'h2222, 2'h3, q);
    check(q, 16'h2222);
    op_q(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'h20, 16'h3344, 2'h1, q);
    check(q, {UNDEFINED_VALUE[15:8], 8'h44});
    op_q(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h20, 16'h0000, 2'h0, q);
    check(q, 16'h1144);
    q0 = a_q;
    op_q(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h21, 16'h0000, 2'h0, q);
    check(q, q0);
    op_q(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h21, 16'h0000, 2'h0, q);
    check(q, q0);
    op_q(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h21, 16'h0000, 2'h0, q);
    check(q, q0);
    q0 = b_q;
    op_q(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 16'h0000, 2'h0, q);
    check(b_q, q0);
    port_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h30, 16'haaaa, 2'h3);
    fork
      port_op(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h30, 16'h0000, 2'h0);
      port_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h30, 16'hbbbb, 2'h3);
    join
    @(posedge clk);
    #1;
    check(a_q, 16'haaaa);
    op_q(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h30, 16'h0000, 2'h0, q);
    check(q, 16'hbbbb);
    // Reset in mid-run must pull both read ports back from nonzero data
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(a_q, DATA_RESET);
    check(b_q, DATA_RESET);
    tally_and_finish();
  end
endmodule : tb_ercrdw_top
